/* File: hw/fcs_pkg.sv */
// constants for the flash control and security register front end
// assumes an 8-bit register port with a 4-bit module offset
package fcs_pkg;
   // --------------------------------------------------
   // register offsets
   // --------------------------------------------------
   localparam logic [3:0] OFS_TIMING_DIVIDER = 4'h0;
   localparam logic [3:0] OFS_LOCK_STATUS = 4'h1;
   localparam logic [3:0] OFS_TEST_SLOT_FIRST = 4'h2;
   localparam logic [3:0] OFS_OPTION_CONTROL = 4'h3;
   localparam logic [3:0] OFS_TEST_ADDRESS_HIGH = 4'h8;
   localparam logic [3:0] OFS_TEST_ADDRESS_LOW = 4'h9;
   localparam logic [3:0] OFS_TEST_DATA_HIGH = 4'ha;
   localparam logic [3:0] OFS_TEST_DATA_LOW = 4'hb;
   localparam logic [3:0] OFS_TEST_SLOT_THIRD = 4'hc;
   localparam logic [3:0] OFS_TEST_SLOT_FOURTH = 4'hd;
   // --------------------------------------------------
   // field positions
   // --------------------------------------------------
   localparam int DIV_WRITTEN_BIT = 7;
   localparam int DIV_PRESCALE_BIT = 6;
   localparam int DIV_VALUE_MSB = 5;
   localparam int DIV_WONCE_MSB = 6;
   localparam int SEC_PERMIT_MSB = 7;
   localparam int SEC_PERMIT_LSB = 6;
   localparam int SEC_USER_MSB = 5;
   localparam int SEC_USER_LSB = 2;
   localparam int SEC_STATE_MSB = 1;
   localparam int SEC_STATE_LSB = 0;
   localparam int OPT_BUF_EMPTY_IE_BIT = 7;
   localparam int OPT_DONE_IE_BIT = 6;
   localparam int OPT_BACKDOOR_BIT = 5;
   // --------------------------------------------------
   // codes and reset values
   // --------------------------------------------------
   localparam logic [1:0] PERMIT_ENABLED = 2'h2;
   localparam logic [1:0] STATE_UNSECURED = 2'h2;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] SEC_RESET = 8'h00;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // --------------------------------------------------
   // timing clock divider and backdoor key
   // --------------------------------------------------
   localparam logic [2:0] PRESCALE_LAST = 3'h7;
   localparam int KEY_WORDS = 4;
endpackage

/* File: hw/fcs_regs.sv */
// flash control and security registers with timing clock divider
// assumes same-clock config load, status flags and array access strobes
`timescale 1ns/1ns
module fcs_regs #(
   parameter int KEY_W = 64
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_cfg_load,
   input wire logic [7:0] i_cfg_sec_byte,
   input wire logic [KEY_W-1:0] i_cfg_key,
   input wire logic i_arr_wr,
   input wire logic [1:0] i_arr_word,
   input wire logic [15:0] i_arr_wdata,
   input wire logic i_buffer_empty_flag,
   input wire logic i_command_done_flag,
   output logic o_irq_req,
   output logic o_cmd_start,
   output logic o_arr_rd_invalid,
   output logic o_timing_tick,
   output logic o_divider_loaded,
   output logic o_secured
);
   // --------------------------------------------------
   // register state
   // --------------------------------------------------
   localparam int KEY_WORDS_W = fcs_pkg::KEY_WORDS;
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic [7:0] sec_q;
   logic [7:0] sec_d;
   logic [7:0] opt_q;
   logic [7:0] opt_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic secured_q;
   logic cmd_start_q;
   logic [2:0] pre_q;
   logic [2:0] pre_d;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic tick_q;
   logic tick_d;
   logic [KEY_WORDS_W-1:0] key_seen_q;
   logic [KEY_WORDS_W-1:0] key_seen_d;
   logic key_ok_q;
   logic key_ok_d;

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
      return addr == offset;
   endfunction

   // only one code of four unlocks, so a blank or corrupt byte stays secure
   function automatic logic state_secured(input logic [1:0] state);
      return state != fcs_pkg::STATE_UNSECURED;
   endfunction

   // --------------------------------------------------
   // address decode
   // --------------------------------------------------
   wire wr_div = i_wr && addr_hit(i_addr, fcs_pkg::OFS_TIMING_DIVIDER);
   wire wr_opt = i_wr && addr_hit(i_addr, fcs_pkg::OFS_OPTION_CONTROL);
   wire [1:0] permit = sec_q[fcs_pkg::SEC_PERMIT_MSB:fcs_pkg::SEC_PERMIT_LSB];
   wire [1:0] lock_state_d = sec_d[fcs_pkg::SEC_STATE_MSB:fcs_pkg::SEC_STATE_LSB];
   wire permit_on = (permit == fcs_pkg::PERMIT_ENABLED);
   wire backdoor_write_mode = opt_q[fcs_pkg::OPT_BACKDOOR_BIT];
   wire buffer_empty_irq_enable = opt_q[fcs_pkg::OPT_BUF_EMPTY_IE_BIT];
   wire done_irq_enable = opt_q[fcs_pkg::OPT_DONE_IE_BIT];
   wire divider_written = div_q[fcs_pkg::DIV_WRITTEN_BIT];
   wire prescale_eight = div_q[fcs_pkg::DIV_PRESCALE_BIT];
   wire [5:0] divide_value = div_q[fcs_pkg::DIV_VALUE_MSB:0];

   // --------------------------------------------------
   // read mux
   // --------------------------------------------------
   // test and reserved slots are not user function, so they read zero
   wire [7:0] rd_mux =
      addr_hit(i_addr, fcs_pkg::OFS_TIMING_DIVIDER) ? div_q :
      addr_hit(i_addr, fcs_pkg::OFS_LOCK_STATUS) ? sec_q :
      addr_hit(i_addr, fcs_pkg::OFS_OPTION_CONTROL) ? opt_q :
      fcs_pkg::READ_ZERO;

   // zero outside the answer cycle, so a late sample never shows stale data
   always_comb
   begin
      rdata_d = fcs_pkg::READ_ZERO;
      if (i_rd)
      begin
         rdata_d = rd_mux;
      end
   end

   // --------------------------------------------------
   // timing divider register
   // --------------------------------------------------
   // write-once, so runaway code cannot retime program pulses later
   always_comb
   begin
      div_d = div_q;
      if (wr_div && !divider_written)
      begin
         div_d[fcs_pkg::DIV_WONCE_MSB:0] = i_wdata[fcs_pkg::DIV_WONCE_MSB:0];
         div_d[fcs_pkg::DIV_WRITTEN_BIT] = 1'b1;
      end
   end

   // --------------------------------------------------
   // timing clock divider
   // --------------------------------------------------
   // held still until software has loaded the divider; total ratio
   // is (divide_value + 1) times 1 or 8, so at most 512
   wire pre_done = !prescale_eight || (pre_q == fcs_pkg::PRESCALE_LAST);
   always_comb
   begin
      pre_d = pre_q;
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (divider_written)
      begin
         pre_d = pre_done ? 3'h0 : pre_q + 3'h1;
         if (pre_done)
         begin
            if (cnt_q == divide_value)
            begin
               cnt_d = 6'h00;
               tick_d = 1'b1;
            end
            else
            begin
               cnt_d = cnt_q + 6'h01;
            end
         end
      end
   end

   // --------------------------------------------------
   // backdoor key comparison
   // --------------------------------------------------
   // a bad word only spoils its round; nothing tells which word failed
   wire key_mode_wr = i_arr_wr && backdoor_write_mode && permit_on;
   wire [15:0] key_word = i_cfg_key[{i_arr_word, 4'h0} +: 16];
   wire [KEY_WORDS_W-1:0] word_bit = KEY_WORDS_W'(1) << i_arr_word;
   wire [KEY_WORDS_W-1:0] seen_next = key_seen_q | word_bit;
   wire match_next = key_ok_q && (i_arr_wdata == key_word);
   wire unlock = key_mode_wr && (&seen_next) && match_next;

   always_comb
   begin
      key_seen_d = key_seen_q;
      key_ok_d = key_ok_q;
      if (!backdoor_write_mode)
      begin
         key_seen_d = '0;
         key_ok_d = 1'b1;
      end
      else if (key_mode_wr)
      begin
         key_seen_d = (&seen_next) ? '0 : seen_next;
         key_ok_d = (&seen_next) ? 1'b1 : match_next;
      end
   end

   // --------------------------------------------------
   // security register
   // --------------------------------------------------
   // bus writes never reach this register; user flags are only stored
   always_comb
   begin
      sec_d = sec_q;
      if (i_cfg_load)
      begin
         sec_d = i_cfg_sec_byte;
      end
      else if (unlock)
      begin
         sec_d[fcs_pkg::SEC_STATE_MSB:fcs_pkg::SEC_STATE_LSB] = fcs_pkg::STATE_UNSECURED;
      end
   end

   // --------------------------------------------------
   // option control register
   // --------------------------------------------------
   // interrupt enables stay writable whatever the lock state
   always_comb
   begin
      opt_d = opt_q;
      if (wr_opt)
      begin
         opt_d[fcs_pkg::OPT_BUF_EMPTY_IE_BIT] = i_wdata[fcs_pkg::OPT_BUF_EMPTY_IE_BIT];
         opt_d[fcs_pkg::OPT_DONE_IE_BIT] = i_wdata[fcs_pkg::OPT_DONE_IE_BIT];
         if (permit_on)
         begin
            opt_d[fcs_pkg::OPT_BACKDOOR_BIT] = i_wdata[fcs_pkg::OPT_BACKDOOR_BIT];
         end
      end
   end

   // --------------------------------------------------
   // flip-flops
   // --------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         div_q <= fcs_pkg::DIV_RESET;
      end
      else
      begin
         div_q <= div_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sec_q <= fcs_pkg::SEC_RESET;
      end
      else
      begin
         sec_q <= sec_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         opt_q <= fcs_pkg::OPT_RESET;
      end
      else
      begin
         opt_q <= opt_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_q <= fcs_pkg::READ_ZERO;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pre_q <= 3'h0;
      end
      else
      begin
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= 6'h00;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         key_seen_q <= '0;
      end
      else
      begin
         key_seen_q <= key_seen_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         key_ok_q <= 1'b1;
      end
      else
      begin
         key_ok_q <= key_ok_d;
      end
   end

   // secure until a load says otherwise, the safe side for access gating
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         secured_q <= 1'b1;
      end
      else
      begin
         secured_q <= state_secured(lock_state_d);
      end
   end

   // no start pulse in key mode, so a key word never launches a command
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cmd_start_q <= 1'b0;
      end
      else
      begin
         cmd_start_q <= i_arr_wr && !backdoor_write_mode;
      end
   end

   // --------------------------------------------------
   // outputs
   // --------------------------------------------------
   assign o_rdata = rdata_q;
   wire irq_buf_empty = buffer_empty_irq_enable && i_buffer_empty_flag;
   wire irq_done = done_irq_enable && i_command_done_flag;
   assign o_irq_req = irq_buf_empty || irq_done;
   assign o_cmd_start = cmd_start_q;
   assign o_arr_rd_invalid = backdoor_write_mode;
   assign o_timing_tick = tick_q;
   assign o_divider_loaded = divider_written;
   assign o_secured = secured_q;
endmodule

/* File: verif/fcs_regs_asserts.sv */
// port checker of the flash control register block
// assumes one clock, async active low reset
`timescale 1ns/1ns
module fcs_regs_asserts (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_cfg_load,
   input wire logic [7:0] i_cfg_sec_byte,
   input wire logic i_arr_wr,
   input wire logic i_buffer_empty_flag,
   input wire logic i_command_done_flag,
   input wire logic o_irq_req,
   input wire logic o_cmd_start,
   input wire logic o_arr_rd_invalid,
   input wire logic o_timing_tick,
   input wire logic o_divider_loaded,
   input wire logic o_secured
);
   // decoded ahead so $past sees a plain signal
   wire logic load_unl = i_cfg_sec_byte[1:0] == 2'h2;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   property p_irq_idle; !i_buffer_empty_flag && !i_command_done_flag |-> !o_irq_req; endproperty
   a_irq_idle: assert property (p_irq_idle) else $error("irq with no flag");
   property p_cmd_start; i_arr_wr && !o_arr_rd_invalid |=> o_cmd_start; endproperty
   a_cmd_start: assert property (p_cmd_start) else $error("no command start");
   property p_cmd_cause; o_cmd_start |-> $past(i_arr_wr) && !$past(o_arr_rd_invalid); endproperty
   a_cmd_cause: assert property (p_cmd_cause) else $error("stray command start");
   property p_rsvd_read; i_rd && !(i_addr inside {4'h0, 4'h1, 4'h3}) |=> o_rdata == 8'h00; endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot not zero");
   property p_opt_read; i_rd && i_addr == 4'h3 |=> o_rdata[4:0] == 5'h00; endproperty
   a_opt_read: assert property (p_opt_read) else $error("option low bits set");
   property p_loaded; o_divider_loaded || (i_wr && i_addr == 4'h0) |=> o_divider_loaded; endproperty
   a_loaded: assert property (p_loaded) else $error("loaded flag wrong");
   property p_sec_load; i_cfg_load |-> ##2 o_secured == !$past(load_unl, 2); endproperty
   a_sec_load: assert property (p_sec_load) else $error("secured state wrong");
   property p_tick_gap; o_timing_tick |-> ##[1:512] o_timing_tick; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick gap too long");
endmodule

bind fcs_regs fcs_regs_asserts i_fcs_regs_asserts (.i_clk_sys, .i_rst_n, .i_addr, .i_wr, .i_rd, .o_rdata,
   .i_cfg_load, .i_cfg_sec_byte, .i_arr_wr, .i_buffer_empty_flag, .i_command_done_flag, .o_irq_req,
   .o_cmd_start, .o_arr_rd_invalid, .o_timing_tick, .o_divider_loaded, .o_secured);

/* File: verif/fcs_regs_tb_top.sv */
// self-checking bench of the flash control register block
// drives all inputs at the rising edge, key input held constant
`timescale 1ns/1ns
module fcs_regs_tb_top;
   logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, ld = 1'h0, aw = 1'h0, bef = 1'h0, cdf = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, sb = 8'h00, rdata;
   logic [1:0] word = 2'h0;
   logic [15:0] awd = 16'h0000;
   logic irq, cmd, inv, tick, loaded, sec;
   logic [63:0] key = 64'h0123_4567_89ab_cdef;
   int bad_count = 0, check_count = 0, cyc = 0;
   fcs_regs i_fcs_regs (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_cfg_load(ld), .i_cfg_sec_byte(sb), .i_cfg_key(key),
      .i_arr_wr(aw), .i_arr_word(word), .i_arr_wdata(awd), .i_buffer_empty_flag(bef),
      .i_command_done_flag(cdf), .o_irq_req(irq), .o_cmd_start(cmd), .o_arr_rd_invalid(inv),
      .o_timing_tick(tick), .o_divider_loaded(loaded), .o_secured(sec));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // longest scenario is about a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk("rdata", exp, rdata);
   endtask
   task automatic load(input logic [7:0] b);
      @(posedge clk);
      sb <= b;
      ld <= 1'h1;
      @(posedge clk);
      ld <= 1'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic arr(input logic [1:0] w, input logic [15:0] d, input logic e);
      @(posedge clk);
      word <= w;
      awd <= d;
      aw <= 1'h1;
      @(posedge clk);
      aw <= 1'h0;
      #1 chk("cmd start", e, cmd);
   endtask
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      while (tick !== 1'h1 && n < 600) @(posedge clk) #1 n++;
      n = 0;
      do @(posedge clk) #1 n++;
      while (tick !== 1'h1 && n < 600);
      chk("tick gap", exp, n);
   endtask
   // write-once divider: a reset is the only way back
   task automatic t_divider(input logic [7:0] v, input int period);
      do_reset();
      #1 chk("loaded", 1'h0, loaded);
      reg_wr(4'h0, v);
      reg_wr(4'h0, ~v);
      #1 chk("loaded", 1'h1, loaded);
      reg_rd(4'h0, v | 8'h80);
      tick_gap(period);
   endtask
   task automatic t_map();
      for (int a = 1; a < 16; a++)
      begin
         reg_wr(4'(a), 8'hff);
         reg_rd(4'(a), a == 3 ? 8'hc0 : 8'h00);
      end
      chk("secured", 1'h1, sec);
   endtask
   task automatic t_security();
      logic [7:0] b;
      for (int c = 0; c < 4; c++)
      begin
         b = {c[1:0], 2'h1, c[1:0], c[1:0]};
         load(b);
         reg_wr(4'h1, ~b);
         reg_rd(4'h1, b);
         chk("secured", c != 2, sec);
         reg_wr(4'h3, 8'hff);
         reg_rd(4'h3, c == 2 ? 8'he0 : 8'hc0);
         chk("invalid read", c == 2, inv);
         reg_wr(4'h3, 8'h00);
      end
   endtask
   task automatic t_irq();
      for (int i = 0; i < 16; i++)
      begin
         reg_wr(4'h3, {i[3:2], 6'h00});
         bef <= i[1];
         cdf <= i[0];
         #1 chk("irq", (i[3] & i[1]) | (i[2] & i[0]), irq);
      end
   endtask
   task automatic t_key();
      load(8'h81);
      reg_wr(4'h3, 8'h20);
      // one wrong word spoils the whole round
      arr(2'h0, ~key[15:0], 1'h0);
      for (int w = 1; w < 4; w++) arr(w[1:0], key[16*w +: 16], 1'h0);
      #40 chk("secured", 1'h1, sec);
      for (int w = 3; w >= 0; w--) arr(w[1:0], key[16*w +: 16], 1'h0);
      #40 reg_rd(4'h1, 8'h82);
      chk("secured", 1'h0, sec);
      reg_wr(4'h3, 8'h00);
      arr(2'h0, 16'h0000, 1'h1);
   endtask
   initial
   begin
      t_divider(8'h45, 48);
      t_divider(8'h05, 6);
      t_divider(8'h7f, 512);
      // software setting: 8 x 32 = 256 clocks, about 195 kHz at 50 MHz
      t_divider(8'h5f, 256);
      t_map();
      t_security();
      t_irq();
      t_key();
      end_of_test();
   end
endmodule
